// file: design/rfd_device.sv
`timescale 1ns/1ps
`default_nettype none
module rfd_device #(
  parameter bit LARGE_PRESCALER = 1'b0
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // serial link from host
  rfd_link_if.dev   link,
  // rf and reference inputs (pins)
  input  wire logic rf_in,
  input  wire logic ref_in,
  // loop status
  output logic      rf_pump_hiz,
  output logic      rf_powered_down,
  output logic      rf_counter_clear,
  output logic      fb_div_pulse,
  output logic      ref_div_pulse
);

  // whole device state in one register so reset and update stay in one place
  typedef struct packed {
    logic [rfd_pkg::NPIN-1:0]   s1;
    logic [rfd_pkg::NPIN-1:0]   s2;
    logic [rfd_pkg::NPIN-1:0]   s3;
    logic [rfd_pkg::NPIN-1:0]   filt;
    logic [rfd_pkg::WORD_W-1:0] shreg;
    logic [rfd_pkg::WORD_W-1:0] r0;
    logic [rfd_pkg::WORD_W-1:0] r1;
    logic                       pd;
    logic [rfd_pkg::MOD_W-1:0]  pre_cnt;
    logic [rfd_pkg::SW_W-1:0]   sw_left;
    logic [rfd_pkg::CNT_W-1:0]  bin_cnt;
    logic [rfd_pkg::CNT_W-1:0]  ref_cnt;
    logic                       fb_pulse;
    logic                       ref_pulse;
  } rfd_dev_state_t;

  rfd_dev_state_t st_ff;
  rfd_dev_state_t nxt_st;

  logic [rfd_pkg::NPIN-1:0]   rise;
  logic [rfd_pkg::NPIN-1:0]   pin_raw;
  logic [rfd_pkg::SW_W-1:0]   swallow;
  logic [rfd_pkg::CNT_W-1:0]  binary;
  logic [rfd_pkg::CNT_W-1:0]  ref_div;
  logic [rfd_pkg::MOD_W-1:0]  mod_low;
  logic [rfd_pkg::MOD_W-1:0]  mod_now;
  logic                       hold;
  // filter and decode helpers
  logic [rfd_pkg::NPIN-1:0]   agree;
  logic [rfd_pkg::NPIN-1:0]   filt_nxt;
  logic                       clr_bit;
  logic                       hiz_bit;
  logic                       pwrdn_bit;
  logic                       psel_bit;
  logic                       pre_wrap;
  logic                       bin_wrap;
  logic                       ref_wrap;

  assign pin_raw[rfd_pkg::PIN_SCLK]  = link.ser_clk;
  assign pin_raw[rfd_pkg::PIN_SDATA] = link.ser_data;
  assign pin_raw[rfd_pkg::PIN_LOAD]  = link.load_strobe;
  assign pin_raw[rfd_pkg::PIN_RF]    = rf_in;
  assign pin_raw[rfd_pkg::PIN_REF]   = ref_in;

  // a level counts once stages 2 and 3 agree, so a one-cycle glitch never lands
  for (genvar g = 0; g < rfd_pkg::NPIN; g++) begin : g_pin
    assign agree[g]    = (st_ff.s2[g] == st_ff.s3[g]);
    assign filt_nxt[g] = agree[g] ? st_ff.s3[g] : st_ff.filt[g];
    assign rise[g]     = agree[g] & st_ff.s3[g] & ~st_ff.filt[g];
  end

  // named views of the stored control words
  assign clr_bit   = st_ff.r0[rfd_pkg::R0_CLEAR];
  assign hiz_bit   = st_ff.r0[rfd_pkg::R0_PUMP_HIZ];
  assign pwrdn_bit = st_ff.r1[rfd_pkg::R1_PWRDN];
  assign psel_bit  = st_ff.r1[rfd_pkg::R1_PSEL];

  // field decode depends on the variant
  always_comb begin
    if (LARGE_PRESCALER) begin
      swallow = st_ff.r1[rfd_pkg::SW_LSB +: rfd_pkg::SW_W_LARGE];
      binary  = {1'b0, st_ff.r1[rfd_pkg::BIN_LSB_LARGE +: rfd_pkg::BIN_W_LARGE]};
      mod_low = psel_bit ? rfd_pkg::MOD_32 : rfd_pkg::MOD_16;
    end else begin
      swallow = {1'b0, st_ff.r1[rfd_pkg::SW_LSB +: rfd_pkg::SW_W_SMALL]};
      binary  = st_ff.r1[rfd_pkg::BIN_LSB_SMALL +: rfd_pkg::BIN_W_SMALL];
      mod_low = psel_bit ? rfd_pkg::MOD_16 : rfd_pkg::MOD_8;
    end
    ref_div = st_ff.r0[rfd_pkg::R0_REF_LSB +: rfd_pkg::REF_W];
  end

  // high modulus while swallow count remains
  assign mod_now = (st_ff.sw_left != '0) ? mod_low + 6'h01 : mod_low;
  // power-down stops counting as a clear does
  assign hold    = clr_bit | st_ff.pd;

  // terminal counts; binary at 3 or more keeps the compare from wrapping
  assign pre_wrap = (st_ff.pre_cnt >= mod_now - 6'h01);
  assign bin_wrap = (st_ff.bin_cnt >= binary - 15'h0001);
  assign ref_wrap = (st_ff.ref_cnt >= ref_div - 15'h0001);

  always_comb begin
    nxt_st      = st_ff;
    // three-stage sampling of every pin
    nxt_st.s1   = pin_raw;
    nxt_st.s2   = st_ff.s1;
    nxt_st.s3   = st_ff.s2;
    nxt_st.filt = filt_nxt;

    // msb enters first and walks toward bit 23
    if (rise[rfd_pkg::PIN_SCLK]) begin
      nxt_st.shreg = {st_ff.shreg[rfd_pkg::WORD_W-2:0],
                      st_ff.filt[rfd_pkg::PIN_SDATA]};
    end
    if (rise[rfd_pkg::PIN_LOAD]) begin
      // other codes reach registers outside this block and are dropped
      unique case (st_ff.shreg[rfd_pkg::ADDR_W-1:0])
        rfd_pkg::ADDR_R0: nxt_st.r0 = st_ff.shreg;
        rfd_pkg::ADDR_R1: nxt_st.r1 = st_ff.shreg;
        default: ;
      endcase
    end

    // async power-down when pump is floated, else wait for a pfd event
    // the sync case waits for the reference edge so the loop stops between
    // comparisons rather than mid-pulse
    if (!pwrdn_bit) begin
      nxt_st.pd = 1'b0;
    end else if (hiz_bit || st_ff.ref_pulse) begin
      nxt_st.pd = 1'b1;
    end

    nxt_st.fb_pulse  = 1'b0;
    nxt_st.ref_pulse = 1'b0;
    if (hold) begin
      // all counters parked at their start so release aligns them exactly
      nxt_st.pre_cnt = '0;
      nxt_st.bin_cnt = '0;
      nxt_st.ref_cnt = '0;
      nxt_st.sw_left = swallow;
    end else begin
      if (rise[rfd_pkg::PIN_RF]) begin
        if (pre_wrap) begin
          nxt_st.pre_cnt = '0;
          if (st_ff.sw_left != '0) begin
            nxt_st.sw_left = st_ff.sw_left - 5'h01;
          end
          if (bin_wrap) begin
            // host keeps binary at 3 or more and swallow not above it
            nxt_st.bin_cnt  = '0;
            nxt_st.sw_left  = swallow;
            nxt_st.fb_pulse = 1'b1;
          end else begin
            nxt_st.bin_cnt = st_ff.bin_cnt + 15'h0001;
          end
        end else begin
          nxt_st.pre_cnt = st_ff.pre_cnt + 6'h01;
        end
      end
      if (rise[rfd_pkg::PIN_REF]) begin
        if (ref_wrap) begin
          nxt_st.ref_cnt   = '0;
          nxt_st.ref_pulse = 1'b1;
        end else begin
          nxt_st.ref_cnt = st_ff.ref_cnt + 15'h0001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // pump float follows the stored bit with no further gating
  assign rf_pump_hiz      = hiz_bit;
  assign rf_powered_down  = st_ff.pd;
  assign rf_counter_clear = clr_bit;
  assign fb_div_pulse     = st_ff.fb_pulse;
  assign ref_div_pulse    = st_ff.ref_pulse;

endmodule : rfd_device
`default_nettype wire

// file: design/rfd_pkg.sv
package rfd_pkg;

  // serial word layout
  localparam int WORD_W       = 24;
  localparam int ADDR_W       = 3;
  localparam logic [2:0] ADDR_R0 = 3'h0;
  localparam logic [2:0] ADDR_R1 = 3'h1;

  // first control word fields
  localparam int R0_REF_LSB   = 3;
  localparam int REF_W        = 15;
  localparam int R0_PUMP_HIZ  = 20;
  localparam int R0_CLEAR     = 21;

  // second control word fields
  localparam int R1_PSEL      = 22;
  localparam int R1_PWRDN     = 23;
  localparam int SW_LSB       = 3;
  localparam int SW_W_SMALL   = 4;
  localparam int SW_W_LARGE   = 5;
  localparam int BIN_LSB_SMALL = 7;
  localparam int BIN_LSB_LARGE = 8;
  localparam int BIN_W_SMALL  = 15;
  localparam int BIN_W_LARGE  = 14;
  localparam int CNT_W        = 15;
  localparam int SW_W         = 5;

  // prescaler low moduli
  localparam int MOD_W        = 6;
  localparam logic [5:0] MOD_8  = 6'h08;
  localparam logic [5:0] MOD_16 = 6'h10;
  localparam logic [5:0] MOD_32 = 6'h20;

  // device pin sampling slots
  localparam int NPIN         = 5;
  localparam int PIN_SCLK     = 0;
  localparam int PIN_SDATA    = 1;
  localparam int PIN_LOAD     = 2;
  localparam int PIN_RF       = 3;
  localparam int PIN_REF      = 4;

  // host register map (byte addresses)
  localparam int AV_ADDR_W    = 4;
  localparam logic [3:0] HOST_WORD_OFS   = 4'h0;
  localparam logic [3:0] HOST_STATUS_OFS = 4'h4;
  localparam int STATUS_BUSY  = 0;
  localparam int HALF_DIV_DEF = 8;

endpackage : rfd_pkg

// file: design/rfd_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rfd_link_if;
  logic ser_clk;
  logic ser_data;
  logic load_strobe;

  modport host (output ser_clk, output ser_data, output load_strobe);
  modport dev  (input ser_clk, input ser_data, input load_strobe);
endinterface : rfd_link_if
`default_nettype wire

// file: design/rfd_host.sv
`timescale 1ns/1ps
`default_nettype none
module rfd_host #(
  parameter int HALF_DIV = rfd_pkg::HALF_DIV_DEF
) (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  // avalon-mm slave
  input  wire logic [rfd_pkg::AV_ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  // serial link to device
  rfd_link_if.host                           link
);

  typedef enum {H_IDLE, H_LOW, H_HIGH, H_LOAD} rfd_host_st_t;

  typedef struct packed {
    rfd_host_st_t               fsm;
    logic [rfd_pkg::WORD_W-1:0] word;
    logic [rfd_pkg::WORD_W-1:0] shift;
    logic [4:0]                 nbit;
    logic [15:0]                div;
    logic                       sclk;
    logic                       sdata;
    logic                       load;
    logic                       wait_r;
    logic [31:0]                rdata;
  } rfd_host_state_t;

  rfd_host_state_t st_ff;
  rfd_host_state_t nxt_st;

  localparam logic [15:0] HALF_M1 = 16'(HALF_DIV - 1);
  localparam logic [4:0]  LAST_BIT = 5'(rfd_pkg::WORD_W - 1);

  logic busy;
  logic req;
  logic word_wr;

  assign busy    = (st_ff.fsm != H_IDLE);
  assign req     = avs_read | avs_write;
  assign word_wr = avs_write & (avs_address == rfd_pkg::HOST_WORD_OFS);

  always_comb begin
    nxt_st = st_ff;
    // answer one cycle after a request is seen, then wait high again;
    // a word write while shifting stalls until the link is idle
    nxt_st.wait_r = 1'b1;
    if (req && st_ff.wait_r && !(word_wr && busy)) begin
      nxt_st.wait_r = 1'b0;
      nxt_st.rdata  = '0;
      if (avs_address == rfd_pkg::HOST_WORD_OFS) begin
        nxt_st.rdata[rfd_pkg::WORD_W-1:0] = st_ff.word;
      end else if (avs_address == rfd_pkg::HOST_STATUS_OFS) begin
        nxt_st.rdata[rfd_pkg::STATUS_BUSY] = 1'b1 & busy;
      end
      if (word_wr) begin
        // fixed-zero bits are software's duty; the word goes out as written
        nxt_st.word  = avs_writedata[rfd_pkg::WORD_W-1:0];
        nxt_st.shift = avs_writedata[rfd_pkg::WORD_W-1:0];
        nxt_st.nbit  = '0;
        nxt_st.div   = '0;
        nxt_st.sclk  = 1'b0;
        nxt_st.sdata = avs_writedata[rfd_pkg::WORD_W-1];
        nxt_st.fsm   = H_LOW;
      end
    end

    if (busy) begin
      nxt_st.div = st_ff.div + 16'h0001;
    end
    unique case (st_ff.fsm)
      H_IDLE: ;
      H_LOW: begin
        if (st_ff.div == HALF_M1) begin
          nxt_st.div  = '0;
          nxt_st.sclk = 1'b1;
          nxt_st.fsm  = H_HIGH;
        end
      end
      H_HIGH: begin
        if (st_ff.div == HALF_M1) begin
          nxt_st.div   = '0;
          nxt_st.sclk  = 1'b0;
          nxt_st.shift = {st_ff.shift[rfd_pkg::WORD_W-2:0], 1'b0};
          nxt_st.sdata = st_ff.shift[rfd_pkg::WORD_W-2];
          nxt_st.nbit  = st_ff.nbit + 5'h01;
          if (st_ff.nbit == LAST_BIT) begin
            nxt_st.load  = 1'b1;
            nxt_st.sdata = 1'b0;
            nxt_st.fsm   = H_LOAD;
          end else begin
            nxt_st.fsm = H_LOW;
          end
        end
      end
      H_LOAD: begin
        if (st_ff.div == HALF_M1) begin
          nxt_st.div  = '0;
          nxt_st.load = 1'b0;
          nxt_st.fsm  = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff        <= '0;
      st_ff.fsm    <= H_IDLE;
      st_ff.wait_r <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata     = st_ff.rdata;
  assign avs_waitrequest  = st_ff.wait_r;
  assign link.ser_clk     = st_ff.sclk;
  assign link.ser_data    = st_ff.sdata;
  assign link.load_strobe = st_ff.load;

endmodule : rfd_host
`default_nettype wire

// file: testbench/rfd_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rfd_assertions #(
  parameter int HALF_DIV = rfd_pkg::HALF_DIV_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // link and device outputs
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire logic rf_pump_hiz,
  input wire logic rf_powered_down,
  input wire logic rf_counter_clear,
  input wire logic fb_div_pulse,
  input wire logic ref_div_pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] hi_ff;
  logic [7:0] nclk_ff;
  logic [3:0] since_ff;
  logic       sclk_q_ff;
  logic       load_q_ff;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_ff     <= 8'h00;
      nclk_ff   <= 8'h00;
      since_ff  <= 4'hf;
      sclk_q_ff <= 1'b0;
      load_q_ff <= 1'b0;
    end else begin
      hi_ff     <= load_strobe ? hi_ff + 8'h01 : 8'h00;
      nclk_ff   <= load_strobe ? 8'h00 : nclk_ff + {7'h00, ser_clk && !sclk_q_ff};
      // saturates so a stray output change long after a load still fails
      since_ff  <= (load_strobe && !load_q_ff) ? 4'h0 : since_ff + {3'h0, since_ff != 4'hf};
      sclk_q_ff <= ser_clk;
      load_q_ff <= load_strobe;
    end
  end
  AST_LOAD_LEN: assert property ($fell(load_strobe) |-> hi_ff == HALF_DIV)
    else $error("load strobe width wrong");
  AST_BITS24: assert property ($rose(load_strobe) |-> nclk_ff == 8'h18)
    else $error("word not 24 clocks");
  AST_DATA_STABLE: assert property (ser_clk && sclk_q_ff |-> $stable(ser_data))
    else $error("data moved while clock high");
  AST_SCLK_LOW: assert property (load_strobe |-> !ser_clk)
    else $error("clock high during load");
  AST_CLEAR_HOLD: assert property (rf_counter_clear [*3] |-> !fb_div_pulse && !ref_div_pulse)
    else $error("divider ran while cleared");
  AST_PD_HOLD: assert property (rf_powered_down [*3] |-> !fb_div_pulse)
    else $error("divider ran while powered down");
  AST_PD_CAUSE: assert property ($rose(rf_powered_down) |-> $past(rf_pump_hiz) || $past(ref_div_pulse))
    else $error("power-down rose without cause");
  AST_OUT_LOAD: assert property (($changed(rf_pump_hiz) || $changed(rf_counter_clear)) |-> since_ff inside {[4'h2:4'h8]})
    else $error("control changed away from a load");
  cover property ($rose(rf_powered_down) && !rf_pump_hiz);
  cover property ($fell(rf_counter_clear));
  cover property ($rose(load_strobe));
endmodule : rfd_assertions
`default_nettype wire

// file: testbench/rf_feedback_divider_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rf_feedback_divider_control_tb;
  typedef struct {logic p; logic [3:0] a; logic [14:0] b;} rfd_row_t;
  localparam int HD = 4;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        rf_in = 1'b0;
  logic        ref_in = 1'b0;
  logic [1:0]  ph = 2'h0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        hiz, pd, clr, fbp, refp;
  logic        fbp_l;
  int          err_total = 0;
  int          num_checks = 0;
  int          c, e;
  logic [31:0] q;
  rfd_row_t    rows [3] = '{'{1'b0, 4'h0, 15'h0003}, '{1'b0, 4'hf, 15'h0010}, '{1'b1, 4'h1, 15'h0003}};

  rfd_link_if rfd_link_if_inst ();
  rfd_host #(.HALF_DIV(HD)) rfd_host_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(rfd_link_if_inst));
  rfd_device #(.LARGE_PRESCALER(1'b0)) rfd_device_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(rfd_link_if_inst), .rf_in(rf_in), .ref_in(ref_in), .rf_pump_hiz(hiz),
    .rf_powered_down(pd), .rf_counter_clear(clr), .fb_div_pulse(fbp), .ref_div_pulse(refp));
  // large variant reads the same link; only its divider output is measured
  rfd_device #(.LARGE_PRESCALER(1'b1)) rfd_device_l_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(rfd_link_if_inst), .rf_in(rf_in), .ref_in(ref_in), .rf_pump_hiz(),
    .rf_powered_down(), .rf_counter_clear(), .fb_div_pulse(fbp_l), .ref_div_pulse());
  rfd_assertions #(.HALF_DIV(HD)) rfd_assertions_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .ser_clk(rfd_link_if_inst.ser_clk), .ser_data(rfd_link_if_inst.ser_data),
    .load_strobe(rfd_link_if_inst.load_strobe), .rf_pump_hiz(hiz), .rf_powered_down(pd),
    .rf_counter_clear(clr), .fb_div_pulse(fbp), .ref_div_pulse(refp));

  always #5 ref_clk = !ref_clk;
  // three cycles per level so each edge survives the device's input filter
  always @(posedge ref_clk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    if (ph == 2'h2) begin
      rf_in  <= !rf_in;
      ref_in <= !ref_in;
    end
  end

  function automatic logic [23:0] w0(input logic cl, input logic hz);
    return {2'h0, cl, hz, 2'h0, 15'h0003, 3'h0};
  endfunction : w0
  function automatic logic [23:0] w1(input logic pdn, input rfd_row_t r);
    return {pdn, r.p, r.b, r.a, 3'h1};
  endfunction : w1
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      err_total++;
      $display("[ERR] %0t bus wait timeout", $time);
    end
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : av
  task automatic wait_idle;
    int n;
    logic [31:0] r;
    n = 0;
    do begin
      av(1'b0, rfd_pkg::HOST_STATUS_OFS, 0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 500);
    if (n >= 500) begin
      err_total++;
      $display("[ERR] %0t link stayed busy", $time);
    end
    repeat (8) @(posedge ref_clk);
  endtask : wait_idle
  task automatic wrw(input logic [23:0] w);
    logic [31:0] r;
    av(1'b1, rfd_pkg::HOST_WORD_OFS, {8'h00, w}, r);
    wait_idle;
  endtask : wrw
  task automatic per(input bit lg, output int n);
    int k;
    k = 0;
    while ((lg ? fbp_l : fbp) !== 1'b1 && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while ((lg ? fbp_l : fbp) !== 1'b1 && n < 3000);
  endtask : per
  task automatic fin(input string s);
    $display("test %s done, errors %0d", s, err_total);
  endtask : fin
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    $display("[ERR] %0t timeout", $time);
    report_and_stop;
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    chk({hiz, pd, clr, avs_waitrequest}, 1);
    rst_b <= 1'b1;
    av(1'b1, 4'hc, 32'h00ff_ffff, q);
    av(1'b0, 4'h8, 0, q);
    chk(q, 0);
    av(1'b0, rfd_pkg::HOST_WORD_OFS, 0, q);
    chk(q, 0);
    fin("reset");
    foreach (rows[i]) begin
      wrw(w1(1'b0, rows[i]));
      wrw(w0(1'b0, 1'b0));
      e = 6 * ((rows[i].p ? rfd_pkg::MOD_16 : rfd_pkg::MOD_8) * rows[i].b + rows[i].a);
      per(1'b0, c);
      chk(c, e);
    end
    // large layout: binary 4 in bits 21:8, swallow 3 in bits 7:3, 16/17 pair
    wrw({1'b0, 1'b0, 14'h0004, 5'h03, 3'h1});
    per(1'b1, c);
    chk(c, 6 * (rfd_pkg::MOD_16 * 4 + 3));
    fin("divider");
    wrw(w0(1'b0, 1'b1));
    chk(hiz, 1);
    wrw(w1(1'b1, rows[2]));
    chk(pd, 1);
    wrw(w1(1'b0, rows[2]));
    chk(pd, 0);
    wrw(w0(1'b0, 1'b0));
    chk(hiz, 0);
    wrw(w1(1'b1, rows[2]));
    repeat (40) @(posedge ref_clk);
    chk(pd, 1);
    wrw(w1(1'b0, rows[2]));
    wrw(w0(1'b0, 1'b1) | 24'h00_0002);
    chk(hiz, 0);
    wrw(w0(1'b0, 1'b1) | 24'h00_0007);
    chk(hiz, 0);
    fin("pump");
    av(1'b1, rfd_pkg::HOST_WORD_OFS, {8'h00, w0(1'b0, 1'b1)}, q);
    av(1'b0, rfd_pkg::HOST_STATUS_OFS, 0, q);
    chk(q[0], 1);
    av(1'b1, rfd_pkg::HOST_WORD_OFS, {8'h00, w0(1'b0, 1'b0)}, q);
    wait_idle;
    chk(hiz, 0);
    av(1'b0, rfd_pkg::HOST_WORD_OFS, 0, q);
    chk(q, {8'h00, w0(1'b0, 1'b0)});
    wrw(w0(1'b1, 1'b0));
    chk(clr, 1);
    repeat (100) @(posedge ref_clk);
    av(1'b1, rfd_pkg::HOST_WORD_OFS, {8'h00, w0(1'b0, 1'b0)}, q);
    for (c = 0; clr !== 1'b0 && c < 1000; c++) @(posedge ref_clk);
    for (c = 0; fbp !== 1'b1 && c < 1000; c++) @(posedge ref_clk);
    chk(c inside {[e - 54:e + 54]}, 1);
    fin("clear");
    wrw(w0(1'b0, 1'b1));
    av(1'b1, rfd_pkg::HOST_WORD_OFS, {8'h00, w0(1'b1, 1'b1)}, q);
    repeat (50) @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({hiz, clr, rfd_link_if_inst.load_strobe, avs_waitrequest}, 1);
    rst_b <= 1'b1;
    av(1'b0, rfd_pkg::HOST_STATUS_OFS, 0, q);
    chk(q, 0);
    fin("midrun reset");
    report_and_stop;
  end
endmodule : rf_feedback_divider_control_tb
`default_nettype wire
